// [dos_clock_ctrl.sv]
// dual oscillator select: run/stop control, cpu clock source choice,
// prescaler and timer0 count source.
// assumes oscillator outputs and pins are asynchronous to i_ref_clk and
// far slower than it; power-down and idle bits come from same-clock logic.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module dos_clock_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [dos_pkg::DOS_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [dos_pkg::DOS_DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [dos_pkg::DOS_DATA_W-1:0] o_avs_readdata,
    output logic [1:0] o_avs_response,
    output logic o_avs_waitrequest,
    input wire logic i_boot_osc_choice,
    input wire logic i_fast_oscillator,
    input wire logic i_slow_oscillator,
    input wire logic i_timer0_ext_input,
    input wire logic i_power_down_bit,
    input wire logic i_idle_bit,
    output logic o_fast_osc_stop,
    output logic o_slow_osc_stop,
    output logic o_cpu_clk,
    output logic o_periph_clk,
    output logic o_timer0_count_src
);
    function automatic logic reg_hit(input logic [dos_pkg::DOS_ADDR_W-1:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // two-stage synchronisers for the oscillator, timer0 and boot strap inputs
    logic [dos_pkg::DOS_SYNC_N-1:0] pin_raw;
    logic [dos_pkg::DOS_SYNC_N-1:0] sync_a;
    logic [dos_pkg::DOS_SYNC_N-1:0] sync_b;
    assign pin_raw[dos_pkg::DOS_SYNC_FAST] = i_fast_oscillator;
    assign pin_raw[dos_pkg::DOS_SYNC_SLOW] = i_slow_oscillator;
    assign pin_raw[dos_pkg::DOS_SYNC_T0] = i_timer0_ext_input;
    assign pin_raw[dos_pkg::DOS_SYNC_BOOT] = i_boot_osc_choice;

    genvar g;
    generate
        for (g = 0; g < dos_pkg::DOS_SYNC_N; g = g + 1) begin : g_sync
            if (g == dos_pkg::DOS_SYNC_BOOT) begin : g_strap
                // strap chain is never cleared: reset loads the control
                // bits from it, so it must carry the strap during reset
                always_ff @(posedge i_ref_clk) begin
                    sync_a[g] <= pin_raw[g];
                    sync_b[g] <= sync_a[g];
                end
            end else begin : g_pin
                always_ff @(posedge i_ref_clk) begin
                    if (i_sys_rst) begin
                        sync_a[g] <= 1'b0;
                        sync_b[g] <= 1'b0;
                    end else begin
                        sync_a[g] <= pin_raw[g];
                        sync_b[g] <= sync_a[g];
                    end
                end
            end
        end
    endgenerate

    wire logic boot_sync = sync_b[dos_pkg::DOS_SYNC_BOOT];
    wire logic fast_sync = sync_b[dos_pkg::DOS_SYNC_FAST];
    wire logic slow_sync = sync_b[dos_pkg::DOS_SYNC_SLOW];
    wire logic t0_sync = sync_b[dos_pkg::DOS_SYNC_T0];

    // bus slave: one wait state on every access
    logic ack;
    wire logic req = i_avs_read | i_avs_write;
    wire logic acc_done = req & ack;
    assign o_avs_waitrequest = req & ~ack;
    assign o_avs_response = dos_pkg::DOS_RESP_OK;

    wire logic hit_sel = reg_hit(i_avs_address, dos_pkg::DOS_IDX_CLK_SRC_SEL);
    wire logic hit_osc = reg_hit(i_avs_address, dos_pkg::DOS_IDX_OSC_CTRL);
    wire logic hit_presc = reg_hit(i_avs_address, dos_pkg::DOS_IDX_PRESC_RELOAD);
    // writes without the low byte lane are dropped: the low byte lane must be enabled
    wire logic byte_ok = i_avs_byteenable[0];
    wire logic wr_ok = i_avs_write & acc_done & byte_ok;

    // registers
    logic cks;
    logic fast_osc_run;
    logic slow_osc_run;
    logic timer0_subclock_sel;
    logic [dos_pkg::DOS_REG_W-1:0] presc_reload;

    wire logic [dos_pkg::DOS_REG_W-1:0] wbyte = i_avs_writedata[dos_pkg::DOS_REG_W-1:0];

    // reset is synchronous and held for three edges, so boot_sync is settled
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cks <= boot_sync;
            fast_osc_run <= boot_sync;
            slow_osc_run <= ~boot_sync;
            timer0_subclock_sel <= dos_pkg::DOS_T0_SUB_RST;
            presc_reload <= dos_pkg::DOS_PRESC_RST;
        end else begin
            // idle bit is never looked at here, so exit keeps all bits
            if (wr_ok && hit_sel) begin
                cks <= wbyte[dos_pkg::DOS_CKS_BIT];
            end
            if (wr_ok && hit_osc) begin
                fast_osc_run <= wbyte[dos_pkg::DOS_FAST_RUN_BIT];
                slow_osc_run <= wbyte[dos_pkg::DOS_SLOW_RUN_BIT];
                timer0_subclock_sel <= wbyte[dos_pkg::DOS_T0_SUB_BIT];
            end
            if (wr_ok && hit_presc) begin
                presc_reload <= wbyte;
            end
        end
    end

    // read data
    wire logic [dos_pkg::DOS_REG_W-1:0] rd_sel = {dos_pkg::DOS_UPPER_RST, cks};
    wire logic [dos_pkg::DOS_REG_W-1:0] rd_osc =
        {5'h00, timer0_subclock_sel, slow_osc_run, fast_osc_run};
    wire logic [dos_pkg::DOS_REG_W-1:0] rd_mux =
        hit_sel ? rd_sel :
        hit_osc ? rd_osc :
        hit_presc ? presc_reload : 8'h00;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ack <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else begin
            ack <= req & ~ack;
            if (i_avs_read && !ack) begin
                o_avs_readdata <= {24'h000000, rd_mux};
            end
        end
    end

    // oscillator stop controls
    wire logic next_fast_stop = i_power_down_bit | ~fast_osc_run;
    wire logic next_slow_stop = i_power_down_bit | ~slow_osc_run;

    // source switch: the active source only changes at a divider wrap that takes cpu clock low,
    // or at once in power-down, so no phase is cut short
    dos_pkg::dos_sw_t sw_state;
    dos_pkg::dos_sw_t next_sw_state;
    logic src_fast;
    logic [dos_pkg::DOS_REG_W-1:0] presc_cnt;
    logic div_clk;
    logic fast_d;
    logic slow_d;

    wire logic fast_rise = fast_sync & ~fast_d;
    wire logic slow_rise = slow_sync & ~slow_d;
    // cks 1 picks the fast source, 0 the slow one
    wire logic src_rise = src_fast ? fast_rise : slow_rise;
    wire logic cnt_wrap = (presc_cnt == 8'hFF);
    wire logic tick = src_rise & ~i_power_down_bit;
    wire logic want_switch = (cks != src_fast);
    wire logic at_low_wrap = tick & cnt_wrap & div_clk;

    always_comb begin
        case (sw_state)
            dos_pkg::DOS_SW_RUN: begin
                next_sw_state = want_switch ? dos_pkg::DOS_SW_WAIT_LOW : dos_pkg::DOS_SW_RUN;
            end
            dos_pkg::DOS_SW_WAIT_LOW: begin
                if (!want_switch) begin
                    next_sw_state = dos_pkg::DOS_SW_RUN;
                end else if (at_low_wrap || i_power_down_bit) begin
                    next_sw_state = dos_pkg::DOS_SW_HANDOVER;
                end else begin
                    next_sw_state = dos_pkg::DOS_SW_WAIT_LOW;
                end
            end
            dos_pkg::DOS_SW_HANDOVER: begin
                next_sw_state = dos_pkg::DOS_SW_RUN;
            end
            default: begin
                next_sw_state = dos_pkg::DOS_SW_RUN;
            end
        endcase
    end

    wire logic do_handover = (sw_state == dos_pkg::DOS_SW_HANDOVER);
    // the divider keeps running on the old source while waiting, so its
    // output can still rise and then fall at a wrap; freezing it while low
    // would never reach the handover point
    wire logic hold_div = do_handover;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sw_state <= dos_pkg::DOS_SW_RUN;
            src_fast <= boot_sync;
            fast_d <= 1'b0;
            slow_d <= 1'b0;
        end else begin
            sw_state <= next_sw_state;
            fast_d <= fast_sync;
            slow_d <= slow_sync;
            if (do_handover) begin
                src_fast <= cks;
            end
        end
    end

    // prescaler: half period is (256 - reload) source edges
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            presc_cnt <= dos_pkg::DOS_PRESC_RST;
            div_clk <= 1'b0;
        end else if (do_handover) begin
            presc_cnt <= presc_reload;
        end else if (tick && !hold_div) begin
            if (cnt_wrap) begin
                presc_cnt <= presc_reload;
                div_clk <= ~div_clk;
            end else begin
                presc_cnt <= presc_cnt + 8'h01;
            end
        end
    end

    // registered clock and control outputs
    wire logic next_periph_clk = div_clk & ~i_power_down_bit;
    wire logic next_cpu_clk = next_periph_clk & ~i_idle_bit;
    wire logic next_t0_src = timer0_subclock_sel ? slow_sync : t0_sync;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_fast_osc_stop <= 1'b0;
            o_slow_osc_stop <= 1'b1;
            o_cpu_clk <= 1'b0;
            o_periph_clk <= 1'b0;
            o_timer0_count_src <= 1'b0;
        end else begin
            o_fast_osc_stop <= next_fast_stop;
            o_slow_osc_stop <= next_slow_stop;
            o_cpu_clk <= next_cpu_clk;
            o_periph_clk <= next_periph_clk;
            o_timer0_count_src <= next_t0_src;
        end
    end
endmodule

`default_nettype wire

// [dos_pkg.sv]
// constants for the dual oscillator select block
// assumes a 32-bit avalon-mm slave with one register per aligned word
package dos_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] DOS_IDX_CLK_SRC_SEL = 8'h85;
    localparam logic [7:0] DOS_IDX_OSC_CTRL = 8'h86;
    localparam logic [7:0] DOS_IDX_PRESC_RELOAD = 8'h8F;
    localparam int DOS_ADDR_W = 10;
    localparam int DOS_DATA_W = 32;
    localparam int DOS_REG_W = 8;

    // field positions
    localparam int DOS_CKS_BIT = 0;
    localparam int DOS_FAST_RUN_BIT = 0;
    localparam int DOS_SLOW_RUN_BIT = 1;
    localparam int DOS_T0_SUB_BIT = 2;

    // reset values of fields not loaded from the boot choice
    localparam logic DOS_T0_SUB_RST = 1'b0;
    localparam logic [7:0] DOS_PRESC_RST = 8'hFF;
    localparam logic [6:0] DOS_UPPER_RST = 7'h00;

    // synchroniser: pin inputs, index into the sync vector
    localparam int DOS_SYNC_N = 4;
    localparam int DOS_SYNC_FAST = 0;
    localparam int DOS_SYNC_SLOW = 1;
    localparam int DOS_SYNC_T0 = 2;
    localparam int DOS_SYNC_BOOT = 3;

    localparam logic [1:0] DOS_RESP_OK = 2'h0;

    typedef enum logic [1:0] {
        DOS_SW_RUN = 2'b00,
        DOS_SW_WAIT_LOW = 2'b01,
        DOS_SW_HANDOVER = 2'b11
    } dos_sw_t;
endpackage

// [dos_clock_ctrl_props.sv]
// checker for the dual oscillator select block
// assumes it is bound into dos_clock_ctrl and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module dos_clock_ctrl_props (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_power_down_bit,
    input wire logic o_fast_osc_stop,
    input wire logic o_slow_osc_stop,
    input wire logic o_cpu_clk,
    input wire logic o_periph_clk
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    wire ctl_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
        && (i_avs_address == {dos_pkg::DOS_IDX_OSC_CTRL, 2'b00});
    wire cks_rd = i_avs_read && !o_avs_waitrequest
        && (i_avs_address == {dos_pkg::DOS_IDX_CLK_SRC_SEL, 2'b00});

    AST_PD_FAST: assert property (i_power_down_bit |=> o_fast_osc_stop)
        else $error("fast oscillator not stopped in power-down");
    AST_PD_SLOW: assert property (i_power_down_bit |=> o_slow_osc_stop)
        else $error("slow oscillator not stopped in power-down");
    AST_PD_CPU: assert property (i_power_down_bit [*3] |-> !o_cpu_clk)
        else $error("cpu clock runs in power-down");
    AST_PD_PERIPH: assert property (i_power_down_bit [*3] |-> !o_periph_clk)
        else $error("peripheral clock runs in power-down");
    AST_FAST_RUN: assert property (ctl_wr ##1 !i_power_down_bit
        |=> o_fast_osc_stop == !$past(i_avs_writedata[0], 2))
        else $error("fast stop does not follow run bit");
    AST_SLOW_RUN: assert property (ctl_wr ##1 !i_power_down_bit
        |=> o_slow_osc_stop == !$past(i_avs_writedata[1], 2))
        else $error("slow stop does not follow run bit");
    AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write)
        && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("access not answered after one wait state");
    AST_CKS_UPPER: assert property (cks_rd |-> o_avs_readdata[31:1] == 31'h0)
        else $error("select register upper bits not zero");
endmodule
bind dos_clock_ctrl dos_clock_ctrl_props u_props (.i_ref_clk, .i_sys_rst, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .i_power_down_bit, .o_fast_osc_stop, .o_slow_osc_stop,
    .o_cpu_clk, .o_periph_clk);
`default_nettype wire

// [dual_oscillator_select_test.sv]
// self-checking bench for the dual oscillator select block
// assumes dos_clock_ctrl and its bound checker; bench plays cpu and pins
`timescale 1ns/10ps
`default_nettype none
module dual_oscillator_select_test;
    localparam logic [9:0] A_CKS = {dos_pkg::DOS_IDX_CLK_SRC_SEL, 2'b00};
    localparam logic [9:0] A_OSC = {dos_pkg::DOS_IDX_OSC_CTRL, 2'b00};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] adr = 10'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic boot = 1'b1;
    logic fo = 1'b0;
    logic so = 1'b0;
    logic t0 = 1'b0;
    logic pd = 1'b0;
    logic idle_bit = 1'b0;
    logic fen = 1'b1;
    logic sen = 1'b1;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic [31:0] d;
    logic wt, fstop, sstop, cpu, per, tsrc;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int cnt;

    dos_clock_ctrl u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_response(), .o_avs_waitrequest(wt),
        .i_boot_osc_choice(boot), .i_fast_oscillator(fo), .i_slow_oscillator(so),
        .i_timer0_ext_input(t0), .i_power_down_bit(pd), .i_idle_bit(idle_bit),
        .o_fast_osc_stop(fstop), .o_slow_osc_stop(sstop), .o_cpu_clk(cpu),
        .o_periph_clk(per), .o_timer0_count_src(tsrc));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // oscillators are slow square waves; a frozen one proves the source
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (fen) fo <= cycles[1];
        if (sen) so <= cycles[4];
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v,
                       input logic [3:0] e);
        @(posedge clk);
        adr <= a;
        wd <= v;
        be <= e;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wt !== 1'b0);
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp, input logic [7:0] m);
        bus(1'b0, a, 32'h0, 4'hF);
        check(rv[7:0] & m, exp);
    endtask

    task automatic count(input int n);
        logic p;
        cnt = 0;
        p = cpu;
        repeat (n) begin
            @(posedge clk);
            if (cpu !== p) cnt++;
            p = cpu;
        end
    endtask

    // strap passes two sync flops, so reset outlasts two cycles
    task automatic boot_chk(input logic b);
        boot <= b;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk(A_CKS, {7'h0, b}, 8'hFF);
        rdchk(A_OSC, {5'h0, 1'b0, !b, b}, 8'h07);
        check({5'h0, fstop, sstop, tsrc}, {5'h0, !b, b, 1'b0});
        $display("test reset done");
    endtask

    initial begin
        void'($urandom(32'hF44B));
        boot_chk(1'b1);
        idle_bit <= 1'b1;
        repeat (20) @(posedge clk);
        idle_bit <= 1'b0;
        rdchk(A_CKS, 8'h01, 8'hFF);
        rdchk(A_OSC, 8'h01, 8'h07);
        $display("test idle done");
        repeat (8) begin
            d = $urandom;
            d[0] = 1'b1;
            bus(1'b1, A_OSC, d, 4'hF);
            repeat (3) @(posedge clk);
            check({6'h0, fstop, sstop}, {6'h0, 1'b0, !d[1]});
            rdchk(A_OSC, d[7:0] & 8'h07, 8'h07);
        end
        bus(1'b1, A_OSC, 32'h3, 4'hE);
        rdchk(A_OSC, d[7:0] & 8'h07, 8'h07);
        bus(1'b1, 10'h220, 32'hFF, 4'hF);
        rdchk(10'h220, 8'h00, 8'hFF);
        $display("test registers done");
        bus(1'b1, A_OSC, 32'h3, 4'h1);
        bus(1'b1, A_CKS, 32'h0, 4'h1);
        // old source must keep running until the handover has happened
        repeat (40) @(posedge clk);
        fen <= 1'b0;
        repeat (200) @(posedge clk);
        count(320);
        check({7'h0, cnt >= 8 && cnt <= 12}, 8'h01);
        bus(1'b1, A_OSC, 32'h2, 4'h1);
        repeat (3) @(posedge clk);
        check({7'h0, fstop}, 8'h01);
        bus(1'b1, A_OSC, 32'h3, 4'h1);
        fen <= 1'b1;
        bus(1'b1, A_CKS, 32'h1, 4'h1);
        repeat (150) @(posedge clk);
        sen <= 1'b0;
        repeat (200) @(posedge clk);
        count(320);
        check({7'h0, cnt >= 78 && cnt <= 82}, 8'h01);
        $display("test switch done");
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, A_OSC, {29'h0, k[0], 2'b11}, 4'h1);
            so <= k[1];
            t0 <= !k[1];
            repeat (6) @(posedge clk);
            check({7'h0, tsrc}, {7'h0, k[0] ? k[1] : !k[1]});
        end
        $display("test timer source done");
        pd <= 1'b1;
        repeat (10) @(posedge clk);
        count(40);
        check({4'h0, fstop, sstop, cpu, per}, 8'h0C);
        check(cnt[7:0], 8'h00);
        pd <= 1'b0;
        $display("test power-down done");
        boot_chk(1'b0);
        close_out();
    end
endmodule
`default_nettype wire
